// ===== test/can_node_model.sv
`timescale 1ns/10ps

// another node on the bus: holds the line dominant for a set time, else recessive
module can_node_model (
    // clock
    input  wire logic        clk,
    // request from the bench
    input  wire logic        go,
    input  wire logic [15:0] dom_len,
    // bus line
    output logic             can_rx
);
    logic [15:0] left_ff;

    initial left_ff = 16'h0000;

    always @(posedge clk) begin
        if (go)
            left_ff <= dom_len;
        else if (left_ff != 16'h0000)
            left_ff <= left_ff - 16'h0001;
    end

    // a released line returns to recessive through the bus termination
    assign can_rx = (left_ff == 16'h0000);
endmodule

// ===== test/tb_top.sv
`timescale 1ns/10ps
`include "can_bit_timing_params.svh"

module tb_top;
    logic                           clk;
    logic                           sys_rst;
    logic                           clk_en;
    logic [`ADDR_W-1:0]             reg_addr;
    logic [7:0]                     reg_wdata;
    logic                           reg_wr;
    logic                           reg_rd;
    logic [7:0]                     reg_rdata;
    logic                           can_rx;
    can_bit_timing_pkg::timing_cfg_t timing_cfg;
    logic                           sys_tick;
    logic                           quantum_tick;
    logic                           bit_start;
    logic                           sample_strobe;
    logic                           sample_bit;
    logic                           go;
    logic [15:0]                    dom_len;
    logic [31:0]                    r;
    logic [7:0]                     d;
    logic [7:0]                     a;
    logic [7:0]                     b;
    logic [7:0]                     c;
    int                             n_fail = 0;
    int                             n_compared = 0;
    int                             cyc = 0;
    int                             seed;
    int                             t0;
    int                             t1;

    can_bit_timing_config dut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .can_rx(can_rx),
        .timing_cfg(timing_cfg), .sys_tick(sys_tick), .quantum_tick(quantum_tick),
        .bit_start(bit_start), .sample_strobe(sample_strobe), .sample_bit(sample_bit)
    );

    can_node_model node (
        .clk(clk), .go(go), .dom_len(dom_len), .can_rx(can_rx)
    );

    always #12.5 clk = ~clk;

    // longest case is a few bits of 6400 cycles each
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ad;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] ad, output logic [7:0] rdv);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    function automatic logic ev(input int w);
        case (w)
            0: return sys_tick;
            1: return quantum_tick;
            2: return bit_start;
            default: return sample_strobe;
        endcase
    endfunction

    task automatic wait_ev(input int w, output int t);
        int k;
        k = 0;
        @(posedge clk);
        #1;
        while (ev(w) !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 20000)
            n_fail++;
        t = cyc;
    endtask

    function automatic can_bit_timing_pkg::timing_cfg_t exp_cfg(input logic [7:0] x,
                                                                input logic [7:0] y,
                                                                input logic [7:0] z);
        exp_cfg.baud_prescaler       = x[6:1];
        exp_cfg.resync_jump_width    = y[6:5];
        exp_cfg.prop_segment         = y[3:1];
        exp_cfg.phase_segment_first  = z[3:1];
        exp_cfg.phase_segment_second = z[6:4];
        exp_cfg.sample_count_select  = z[0];
    endfunction

    function automatic int exp_q(input logic mode, input int presc);
        return (mode ? `DIV_MODE1 : `DIV_MODE0) * (presc + 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic run_cfg(input logic [5:0] presc, input logic [2:0] prop,
                           input logic [2:0] p1, input logic [2:0] p2, input logic mode);
        int q;
        int ts;
        int n;
        q = exp_q(mode, presc);
        n = 3 + prop + p1;
        wr(3'h0, {1'b0, presc, 1'b0});
        wr(3'h1, {4'h0, prop, 1'b0});
        wr(3'h2, {1'b0, p2, p1, 1'b0});
        wr(3'h3, {7'h00, mode});
        wait_ev(0, t0);
        wait_ev(0, t1);
        chk(t1 - t0, mode ? `DIV_MODE1 : `DIV_MODE0);
        wait_ev(1, t0);
        wait_ev(1, t0);
        wait_ev(1, t1);
        chk(t1 - t0, q);
        wait_ev(2, t0);
        wait_ev(2, t0);
        wait_ev(3, ts);
        wait_ev(2, t1);
        chk(t1 - t0, q * (4 + prop + p1 + p2));
        chk((ts - t0 >= n * q - 1) && (ts - t0 <= n * q + 2), 1);
    endtask

    initial begin
        clk       = 1'b0;
        sys_rst   = 1'b1;
        clk_en    = 1'b1;
        reg_addr  = 3'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        go        = 1'b0;
        dom_len   = 16'h0000;
        seed      = 32'h004195D6;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // reset state: all fields zero, so four quanta per bit
        for (int i = 0; i < 4; i++) begin
            rd(3'(i), d);
            chk(d, 0);
        end
        rd(3'h6, d);
        chk(d, 4);
        // register map, masks, read-only and unmapped places
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
            b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[15:8];
            c = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[23:16];
            wr(3'h0, a);
            wr(3'h1, b);
            wr(3'h2, c);
            wr(3'h3, {7'h00, r[24]});
            wr(3'(4 + i % 4), r[31:24]);
            rd(3'h0, d);
            chk(d, a & 8'h7E);
            rd(3'h1, d);
            chk(d, b & 8'h6E);
            rd(3'h2, d);
            chk(d, c & 8'h7F);
            rd(3'h3, d);
            chk(d, r[24]);
            rd(3'h7, d);
            chk(d, 0);
            rd(3'h5, d);
            chk(d, 3 + b[3:1] + c[3:1]);
            rd(3'h6, d);
            chk(d, 4 + b[3:1] + c[3:1] + c[6:4]);
            chk({15'h0000, timing_cfg}, {15'h0000, exp_cfg(a, b, c)});
        end
        // a write while the clock enable is low must not land
        @(posedge clk);
        clk_en    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= 3'h0;
        reg_wdata <= ~a;
        @(posedge clk);
        reg_wr    <= 1'b0;
        repeat (4) @(posedge clk);
        clk_en    <= 1'b1;
        rd(3'h0, d);
        chk(d, a & 8'h7E);
        // segment timing: corners, then random settings
        run_cfg(6'h00, 3'h0, 3'h0, 3'h0, 1'b1);
        run_cfg(6'h3F, 3'h7, 3'h7, 3'h7, 1'b0);
        run_cfg(6'h05, 3'h7, 3'h0, 3'h3, 1'b1);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            run_cfg({3'h0, r[2:0]}, r[5:3], r[8:6], r[11:9], r[12]);
        end
        // hard sync from a falling edge in phase 2, then single and triple sampling
        for (int s = 0; s < 2; s++) begin
            wr(3'h0, 8'h06);
            wr(3'h1, 8'h00);
            wr(3'h2, {1'b0, 3'h7, 3'h0, s[0]});
            wr(3'h3, 8'h01);
            wait_ev(2, t0);
            wait_ev(2, t0);
            repeat (50) @(posedge clk);
            go      <= 1'b1;
            dom_len <= 16'h0190;
            @(posedge clk);
            go      <= 1'b0;
            t0 = cyc;
            wait_ev(2, t1);
            chk(t1 - t0 <= 8, 1);
            wait_ev(3, t1);
            wait_ev(3, t1);
            chk(sample_bit, 1'b0);
            repeat (400) @(posedge clk);
            wait_ev(3, t1);
            wait_ev(3, t1);
            chk(sample_bit, 1'b1);
        end
        test_done();
    end
endmodule

// ===== verilog/can_bit_timing_config.sv
`timescale 1ns/10ps
`include "can_bit_timing_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// R01: software picks mode 0 below 12Kbps
// R02: mode 1 ticks 20MHz, mode 0 10MHz
// R03: bit cycles equal system clock over bitrate
// R04: quantum is prescaler plus one ticks
// R05: sync segment fixed at one quantum
// R06: each programmable segment is field plus one
// R07: bit is four plus segment fields quanta
// R08: segment fields three bits, zero to seven
// R09: prescaler field holds up to 63
// R10: sample after sync, propagation, first phase
// R11: first register prescaler in bits 6..1
// R12: second register jump width, propagation fields
// R13: third register phases and sample select
// R14: software leaves jump width, select at zero
// R15: select set takes three-sample majority vote
// R16: restart count per bit, hard sync edges
module can_bit_timing_config (
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // register port
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // can bus receive pin
    input  wire logic                 can_rx,
    // bit timing to the protocol controller
    output can_bit_timing_pkg::timing_cfg_t timing_cfg,
    output logic                      sys_tick,
    output logic                      quantum_tick,
    output logic                      bit_start,
    output logic                      sample_strobe,
    output logic                      sample_bit
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]                        presc_reg_ff;
    logic [7:0]                        jump_reg_ff;
    logic [7:0]                        phase_reg_ff;
    logic                              clock_mode_ff;
    logic [7:0]                        rdata_ff;
    can_bit_timing_pkg::timing_cfg_t   cfg_ff;

    logic sel_presc;
    logic sel_jump;
    logic sel_phase;
    logic sel_mode;
    logic sel_status;
    logic sel_spoint;
    logic sel_bquanta;
    logic [7:0] nxt_rdata;

    assign sel_presc   = (reg_addr == `OFS_PRESCALER);
    assign sel_jump    = (reg_addr == `OFS_JUMP_PROP);
    assign sel_phase   = (reg_addr == `OFS_PHASE_SAMPLE);
    assign sel_mode    = (reg_addr == `OFS_CLOCK_MODE);
    assign sel_status  = (reg_addr == `OFS_STATUS);
    assign sel_spoint  = (reg_addr == `OFS_SAMPLE_POINT);
    assign sel_bquanta = (reg_addr == `OFS_BIT_QUANTA);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            presc_reg_ff  <= `RST_PRESCALER;
            jump_reg_ff   <= `RST_JUMP_PROP;
            phase_reg_ff  <= `RST_PHASE_SAMPLE;
            clock_mode_ff <= `RST_CLOCK_MODE;
        end else if (clk_en && reg_wr) begin
            if (sel_presc) begin
                presc_reg_ff <= reg_wdata & `MASK_PRESCALER; // [R11]
            end else if (sel_jump) begin
                jump_reg_ff <= reg_wdata & `MASK_JUMP_PROP; // [R12]
            end else if (sel_phase) begin
                phase_reg_ff <= reg_wdata & `MASK_PHASE_SAMPLE; // [R13]
            end else if (sel_mode) begin
                clock_mode_ff <= reg_wdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    can_bit_timing_pkg::timing_cfg_t cfg_now;

    assign cfg_now.baud_prescaler       = presc_reg_ff[`PRESC_HI:`PRESC_LO]; // [R09] [R11]
    assign cfg_now.resync_jump_width    = jump_reg_ff[`SJW_HI:`SJW_LO]; // [R12] [R14]
    assign cfg_now.prop_segment         = jump_reg_ff[`PROP_HI:`PROP_LO]; // [R08] [R12]
    assign cfg_now.phase_segment_second = phase_reg_ff[`PHASE_SEGMENT_SECOND_HI:`PHASE_SEGMENT_SECOND_LO]; // [R08] [R13]
    assign cfg_now.phase_segment_first  = phase_reg_ff[`PHASE_SEGMENT_FIRST_HI:`PHASE_SEGMENT_FIRST_LO]; // [R08] [R13]
    assign cfg_now.sample_count_select  = phase_reg_ff[`SMP_BIT]; // [R13]

    // segment lengths in quanta; sync is fixed, others are field plus one
    logic [4:0] bit_quanta;
    logic [4:0] sample_quanta;

    assign bit_quanta    = `BIT_QUANTA_BASE + {2'h0, cfg_now.prop_segment}
                         + {2'h0, cfg_now.phase_segment_first}
                         + {2'h0, cfg_now.phase_segment_second}; // [R06] [R07]
    assign sample_quanta = `SAMPLE_QUANTA_BASE + {2'h0, cfg_now.prop_segment}
                         + {2'h0, cfg_now.phase_segment_first}; // [R10]

    ////////////////////////////////////////////////////////////////////////////
    // system clock tick from the clock mode

    logic [`DIV_W-1:0] div_ff;
    logic [`DIV_W-1:0] div_last;
    logic              div_wrap;
    logic [`DIV_W-1:0] nxt_div;
    logic              tick_ff;

    // mode 1 ticks at 20MHz, mode 0 at 10MHz; mode choice is software's [R01]
    assign div_last = clock_mode_ff ? `DIV_W'(`DIV_MODE1 - 1)
                                    : `DIV_W'(`DIV_MODE0 - 1); // [R02]
    assign div_wrap = (div_ff >= div_last);
    assign nxt_div  = div_wrap ? '0 : div_ff + `DIV_W'(1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_ff  <= '0;
            tick_ff <= 1'h0;
        end else if (clk_en) begin
            div_ff  <= nxt_div;
            tick_ff <= div_wrap; // [R02]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // quantum prescaler and bit segmentation

    logic [5:0] presc_cnt_ff;
    logic [4:0] quanta_cnt_ff;
    logic       q_end;
    logic       bit_end;
    logic       q_tick_ff;
    logic       bit_start_ff;
    logic       take_sample;
    logic       strobe_ff;
    logic       rx_level;
    logic       fall_edge;
    logic       sample_value;
    logic       hard_sync;
    logic [5:0] nxt_presc;
    logic [4:0] nxt_quanta;
    can_bit_timing_pkg::segment_t seg_ff;
    can_bit_timing_pkg::segment_t nxt_seg;

    // one quantum is prescaler plus one system ticks [R04]
    assign q_end    = tick_ff && (presc_cnt_ff >= cfg_now.baud_prescaler);
    // bit length is quantum times total quanta, so cycles follow clock over rate [R03]
    assign bit_end  = q_end && (quanta_cnt_ff >= bit_quanta - 5'h01);
    // hard sync only from recessive to dominant while in phase 2
    assign hard_sync = fall_edge && (seg_ff == can_bit_timing_pkg::SEG_PHASE2);
    assign take_sample = q_end && (quanta_cnt_ff == sample_quanta - 5'h01); // [R10]

    assign nxt_presc  = (hard_sync || q_end) ? 6'h00
                      : (tick_ff ? presc_cnt_ff + 6'h01 : presc_cnt_ff);
    assign nxt_quanta = (hard_sync || bit_end) ? 5'h00
                      : (q_end ? quanta_cnt_ff + 5'h01 : quanta_cnt_ff); // [R16]

    always_comb begin
        nxt_seg = seg_ff;
        if (hard_sync || bit_end) begin
            nxt_seg = can_bit_timing_pkg::SEG_SYNC; // [R16]
        end else if (q_end) begin
            case (seg_ff)
                can_bit_timing_pkg::SEG_SYNC: begin
                    nxt_seg = can_bit_timing_pkg::SEG_PROP; // [R05]
                end
                can_bit_timing_pkg::SEG_PROP: begin
                    // a field rewritten mid-bit may leave the count past the boundary
                    if (take_sample)
                        nxt_seg = can_bit_timing_pkg::SEG_PHASE2;
                    else if (quanta_cnt_ff >= `SYNC_QUANTA + {2'h0, cfg_now.prop_segment})
                        nxt_seg = can_bit_timing_pkg::SEG_PHASE1;
                end
                can_bit_timing_pkg::SEG_PHASE1: begin
                    if (take_sample)
                        nxt_seg = can_bit_timing_pkg::SEG_PHASE2;
                end
                default: begin
                    nxt_seg = can_bit_timing_pkg::SEG_PHASE2;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            presc_cnt_ff  <= 6'h00;
            quanta_cnt_ff <= 5'h00;
            seg_ff        <= can_bit_timing_pkg::SEG_SYNC;
            q_tick_ff     <= 1'h0;
            bit_start_ff  <= 1'h0;
            strobe_ff     <= 1'h0;
        end else if (clk_en) begin
            presc_cnt_ff  <= nxt_presc;
            quanta_cnt_ff <= nxt_quanta;
            seg_ff        <= nxt_seg;
            q_tick_ff     <= q_end;
            bit_start_ff  <= bit_end || hard_sync; // [R16]
            strobe_ff     <= take_sample;
        end
    end

    can_bus_sampler u_sampler (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .clk_en       (clk_en),
        .tick         (tick_ff),
        .triple       (cfg_now.sample_count_select),
        .take         (take_sample),
        .can_rx       (can_rx),
        .rx_level     (rx_level),
        .fall_edge    (fall_edge),
        .sample_value (sample_value)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read path and registered outputs

    logic [7:0] status_word;

    assign status_word = {4'h0, rx_level, 1'h0, seg_ff};

    always_comb begin
        if (sel_presc) begin
            nxt_rdata = presc_reg_ff;
        end else if (sel_jump) begin
            nxt_rdata = jump_reg_ff;
        end else if (sel_phase) begin
            nxt_rdata = phase_reg_ff;
        end else if (sel_mode) begin
            nxt_rdata = {7'h00, clock_mode_ff};
        end else if (sel_status) begin
            nxt_rdata = status_word;
        end else if (sel_spoint) begin
            nxt_rdata = {3'h0, sample_quanta};
        end else if (sel_bquanta) begin
            nxt_rdata = {3'h0, bit_quanta};
        end else begin
            nxt_rdata = 8'h00;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
            cfg_ff   <= '0;
        end else if (clk_en) begin
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
            cfg_ff   <= cfg_now;
        end
    end

    assign reg_rdata     = rdata_ff;
    assign timing_cfg    = cfg_ff;
    assign sys_tick      = tick_ff;
    assign quantum_tick  = q_tick_ff;
    assign bit_start     = bit_start_ff;
    assign sample_strobe = strobe_ff;
    assign sample_bit    = sample_value;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_BIT_MAX: assert property (@(posedge clk) disable iff (sys_rst) // [R07]
        bit_quanta <= `MAX_BIT_QUANTA)
        else $error("bit quanta above maximum");

    AST_QCOUNT: assert property (@(posedge clk) disable iff (sys_rst) // [R04]
        (clk_en && q_end) |=> presc_cnt_ff == 6'h00)
        else $error("prescaler count not restarted at quantum end");

    AST_SAMPLE_POS: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
        (clk_en && take_sample && !hard_sync) |=> seg_ff == can_bit_timing_pkg::SEG_PHASE2)
        else $error("sample not at end of first phase");

    AST_SYNC_ONE: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
        (clk_en && seg_ff == can_bit_timing_pkg::SEG_SYNC && q_end && !hard_sync)
            |=> seg_ff == can_bit_timing_pkg::SEG_PROP)
        else $error("sync segment longer than one quantum");

    AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
        (clk_en && bit_end) |=> (quanta_cnt_ff == 5'h00 && bit_start))
        else $error("quantum count not restarted");

    AST_TICK_RATE: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
        (clk_en && !clock_mode_ff && tick_ff && $stable(clock_mode_ff)) |=> !tick_ff)
        else $error("mode 0 tick too fast");

    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
        (presc_reg_ff[7] == 1'h0) && (presc_reg_ff[0] == 1'h0)
            && (jump_reg_ff[4] == 1'h0) && (jump_reg_ff[0] == 1'h0))
        else $error("unused register bits set");

    AST_RD_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");

endmodule

// ===== verilog/can_bit_timing_params.svh
`ifndef CAN_BIT_TIMING_PARAMS_SVH
`define CAN_BIT_TIMING_PARAMS_SVH

// register offsets on the plain port
`define ADDR_W              3
`define OFS_PRESCALER       3'h0
`define OFS_JUMP_PROP       3'h1
`define OFS_PHASE_SAMPLE    3'h2
`define OFS_CLOCK_MODE      3'h3
`define OFS_STATUS          3'h4
`define OFS_SAMPLE_POINT    3'h5
`define OFS_BIT_QUANTA      3'h6

// field positions
`define PRESC_HI            6
`define PRESC_LO            1
`define SJW_HI              6
`define SJW_LO              5
`define PROP_HI             3
`define PROP_LO             1
`define PHASE_SEGMENT_SECOND_HI             6
`define PHASE_SEGMENT_SECOND_LO             4
`define PHASE_SEGMENT_FIRST_HI             3
`define PHASE_SEGMENT_FIRST_LO             1
`define SMP_BIT             0

// masks keep unused bits reading as zero
`define MASK_PRESCALER      8'h7E
`define MASK_JUMP_PROP      8'h6E
`define MASK_PHASE_SAMPLE   8'h7F

// reset values
`define RST_PRESCALER       8'h00
`define RST_JUMP_PROP       8'h00
`define RST_PHASE_SAMPLE    8'h00
`define RST_CLOCK_MODE      1'h0

// fixed quanta: sync segment and the plus-one of three segments
`define SYNC_QUANTA         5'h01
`define BIT_QUANTA_BASE     5'h04
`define SAMPLE_QUANTA_BASE  5'h03
`define MAX_BIT_QUANTA      5'h19

// system clock rates per clock mode, in MHz
`define SYS_MHZ_MODE1       20
`define SYS_MHZ_MODE0       10
`define CLK_MHZ             40
`define DIV_MODE1           (`CLK_MHZ / `SYS_MHZ_MODE1)
`define DIV_MODE0           (`CLK_MHZ / `SYS_MHZ_MODE0)
`define DIV_W               2

`endif

// ===== verilog/can_bit_timing_pkg.sv
package can_bit_timing_pkg;

    typedef struct packed {
        logic [5:0] baud_prescaler;
        logic [1:0] resync_jump_width;
        logic [2:0] prop_segment;
        logic [2:0] phase_segment_first;
        logic [2:0] phase_segment_second;
        logic       sample_count_select;
    } timing_cfg_t;

    typedef struct packed {
        logic sample_strobe;
        logic sample_bit;
        logic bit_start;
    } bit_event_t;

    typedef enum logic [1:0] {
        SEG_SYNC,
        SEG_PROP,
        SEG_PHASE1,
        SEG_PHASE2
    } segment_t;

endpackage

// ===== verilog/can_bus_sampler.sv
`timescale 1ns/10ps
`include "can_bit_timing_params.svh"

// takes the bus level through three flops and forms a single or majority sample
module can_bus_sampler (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // sampling control
    input  wire logic tick,
    input  wire logic triple,
    input  wire logic take,
    // bus pin
    input  wire logic can_rx,
    // results
    output logic      rx_level,
    output logic      fall_edge,
    output logic      sample_value
);

    logic       sync1_ff;
    logic       sync2_ff;
    logic       sync3_ff;
    logic       level_ff;
    logic [2:0] hist_ff;
    logic       sample_ff;
    logic       fall_ff;
    logic       agree;
    logic       majority;
    logic       nxt_level;
    logic [2:0] nxt_hist;

    // a change counts only once the second and third flops agree
    assign agree     = (sync2_ff == sync3_ff);
    assign nxt_level = agree ? sync3_ff : level_ff;
    // history shifts on system ticks, spacing samples a full tick apart
    assign nxt_hist  = tick ? {hist_ff[1:0], level_ff} : hist_ff;
    assign majority  = (hist_ff[0] & hist_ff[1]) | (hist_ff[1] & hist_ff[2])
                     | (hist_ff[0] & hist_ff[2]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff  <= 1'h1;
            sync2_ff  <= 1'h1;
            sync3_ff  <= 1'h1;
            level_ff  <= 1'h1;
            hist_ff   <= 3'h7;
            sample_ff <= 1'h1;
            fall_ff   <= 1'h0;
        end else if (clk_en) begin
            sync1_ff  <= can_rx;
            sync2_ff  <= sync1_ff;
            sync3_ff  <= sync2_ff;
            level_ff  <= nxt_level;
            hist_ff   <= nxt_hist;
            fall_ff   <= level_ff & ~nxt_level;
            if (take) begin
                sample_ff <= triple ? majority : level_ff; // [R15]
            end
        end
    end

    assign rx_level     = level_ff;
    assign fall_edge    = fall_ff;
    assign sample_value = sample_ff;

endmodule
